//--- design/pmfs_top.sv
// What this block does
// - flag starter fault on feedback mismatch in auto
// - start delay defaults 2 s, range 2-510
// - zero delay disables fault, output stays on
// - start-faulted pump locked out until sequence ends
// - retry failed pump on next pump cycle
// - start fault clears on feedback or leaving auto
// - start fault raises alarm, flashes pump indicator
// - stop fault on feedback without output
// - stop delay defaults 2 s, range 2-510
// - retry calls faulted pump, feedback clears fault
// - no retry: fault held until override or leaving auto
// - no retry: pump out, new lead chosen
// - transducer fault from configured conditions
// - backup level scheme until fixed and reset
// - no backup: suspend auto, light and horn
// - leaving alarm view drops inactive alarms
// - alarm indicator flashes active, steady unviewed
`timescale 1ns/10ps
`default_nettype none
module pmfs_top #(
	parameter int NUM_PUMPS    = pmfs_pkg::PUMPS_DEF,
	parameter int TICK_CYCLES  = pmfs_pkg::TICK_CYCLES,
	parameter int FLASH_CYCLES = pmfs_pkg::FLASH_CYCLES
) (
	// clock and reset
	input  wire logic                  clock_in,
	input  wire logic                  sys_rst_in,
	// pump selector switches and feedback
	input  wire logic [NUM_PUMPS-1:0]  hoa_auto_in,
	input  wire logic [NUM_PUMPS-1:0]  remote_ovr_in,
	input  wire logic [NUM_PUMPS-1:0]  run_fb_in,
	// follow delay and retry configuration
	input  wire logic [8:0]            start_dly_in,
	input  wire logic [8:0]            stop_dly_in,
	input  wire logic                  dly_dflt_in,
	input  wire logic                  auto_retry_in,
	// transducer fault and backup configuration
	input  wire pmfs_pkg::pmfs_xdcfg_t xd_cfg_in,
	input  wire pmfs_pkg::pmfs_backup_t backup_in,
	input  wire logic                  horn_en_in,
	// level reports from each level source
	input  wire pmfs_pkg::pmfs_lvl_t   lvl_xd1_in,
	input  wire pmfs_pkg::pmfs_lvl_t   lvl_xd2_in,
	input  wire pmfs_pkg::pmfs_lvl_t   lvl_flt_in,
	input  wire logic                  timer_call_in,
	input  wire logic                  hi_float_in,
	input  wire logic                  lo_float_in,
	// transducer health
	input  wire logic                  xd_low_in,
	input  wire logic                  bubbler_noise_in,
	input  wire logic                  xd_reset_in,
	// operator alarm view
	input  wire logic                  alarm_view_in,
	// starter outputs and pump indicators
	output logic [NUM_PUMPS-1:0]       run_out,
	output logic [NUM_PUMPS-1:0]       pump_led_out,
	output logic [NUM_PUMPS-1:0]       start_flt_out,
	output logic [NUM_PUMPS-1:0]       stop_flt_out,
	// alarm and station status
	output pmfs_pkg::pmfs_alarm_t      alarm_act_out,
	output pmfs_pkg::pmfs_alarm_t      alarm_log_out,
	output logic                       alarm_led_out,
	output logic                       alarm_light_out,
	output logic                       horn_out,
	output logic                       xd_fault_out,
	output logic                       auto_suspend_out,
	output logic                       seq_active_out,
	output logic [$clog2(NUM_PUMPS)-1:0] lead_out
);
	import pmfs_pkg::*;

	localparam int LEAD_W  = $clog2(NUM_PUMPS);
	localparam int TICK_W  = $clog2(TICK_CYCLES);
	localparam int FLASH_W = $clog2(FLASH_CYCLES);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (NUM_PUMPS < 2 || NUM_PUMPS > PUMPS_MAX) begin : g_bad_pumps
		$error("pump count out of range");
	end
	if (TICK_CYCLES < 2 || FLASH_CYCLES < 2) begin : g_bad_div
		$error("divider counts too small");
	end

	// ----------------------------------------
	// time base: one-second tick and flash phase
	// ----------------------------------------
	logic [TICK_W-1:0]  tick_cnt_ff;
	logic               sec_tick_ff;
	logic [FLASH_W-1:0] flash_cnt_ff;
	logic               blink_ff;
	wire logic          tick_wrap_w;
	wire logic          flash_wrap_w;

	assign tick_wrap_w  = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
	assign flash_wrap_w = (flash_cnt_ff == FLASH_W'(FLASH_CYCLES - 1));

	// dividers share the one clock, slow rates are enables only
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			tick_cnt_ff  <= '0;
			sec_tick_ff  <= 1'b0;
			flash_cnt_ff <= '0;
			blink_ff     <= 1'b0;
		end else begin
			tick_cnt_ff  <= tick_wrap_w ? '0 : tick_cnt_ff + TICK_W'(1);
			sec_tick_ff  <= tick_wrap_w;
			flash_cnt_ff <= flash_wrap_w ? '0 : flash_cnt_ff + FLASH_W'(1);
			blink_ff     <= blink_ff ^ flash_wrap_w;
		end
	end

	// ----------------------------------------
	// follow delay selection
	// ----------------------------------------
	wire logic [DLY_W-1:0] start_dly_w;
	wire logic [DLY_W-1:0] stop_dly_w;
	pmfs_cfg_t             cfg;

	// a nonzero setting below the floor is raised to it rather than rejected
	assign start_dly_w = dly_dflt_in ? DLY_DEF :
	                     (start_dly_in == DLY_OFF) ? DLY_OFF :
	                     (start_dly_in < DLY_MIN) ? DLY_MIN :
	                     (start_dly_in > DLY_MAX) ? DLY_MAX : start_dly_in;
	assign stop_dly_w  = dly_dflt_in ? DLY_DEF :
	                     (stop_dly_in == DLY_OFF) ? DLY_OFF :
	                     (stop_dly_in < DLY_MIN) ? DLY_MIN :
	                     (stop_dly_in > DLY_MAX) ? DLY_MAX : stop_dly_in;
	assign cfg = '{start_dly: start_dly_w, stop_dly: stop_dly_w, auto_retry: auto_retry_in};

	// ----------------------------------------
	// transducer fault and level source
	// ----------------------------------------
	logic      xd_fault_ff;
	wire logic xd_cond_w;
	wire logic suspend_w;
	wire logic combo_w;
	pmfs_lvl_t lvl_bk;
	pmfs_lvl_t lvl;

	// a high float only counts while the transducer is in control
	assign xd_cond_w = (xd_cfg_in.en_low & xd_low_in)
	                   | (xd_cfg_in.en_hi_float & hi_float_in & ~xd_fault_ff)
	                   | (xd_cfg_in.en_bubbler & ~bubbler_noise_in);

	// fault holds until the condition is gone and an operator reset comes
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			xd_fault_ff <= 1'b0;
		end else begin
			xd_fault_ff <= xd_cond_w | (xd_fault_ff & ~xd_reset_in);
		end
	end

	// backup scheme picks the level report once the transducer is faulted
	assign combo_w   = (backup_in == BK_COMBO);
	assign suspend_w = xd_fault_ff & (backup_in == BK_NONE);
	assign lvl_bk    = (backup_in == BK_FLOAT) ? lvl_flt_in :
	                   (backup_in == BK_TIMER) ? pmfs_lvl_t'{off: ~timer_call_in, lead: timer_call_in, lag: 1'b0} :
	                   (backup_in == BK_XDCR2 || combo_w) ? lvl_xd2_in :
	                   pmfs_lvl_t'{off: 1'b1, lead: 1'b0, lag: 1'b0};
	// in the combined scheme the floats override the second source
	assign lvl = !xd_fault_ff ? lvl_xd1_in :
	             pmfs_lvl_t'{off: lvl_bk.off | (combo_w & lo_float_in),
	               lead: lvl_bk.lead,
	               lag: lvl_bk.lag | (combo_w & hi_float_in)};

	// ----------------------------------------
	// pumping sequence and demand
	// ----------------------------------------
	pmfs_seq_t             seq_ff;
	pmfs_seq_t             nxt_seq;
	logic [1:0]            need_ff;
	logic [1:0]            nxt_need;
	logic [LEAD_W-1:0]     lead_ff;
	logic [NUM_PUMPS-1:0]  avail;
	logic [NUM_PUMPS-1:0]  call;
	logic [NUM_PUMPS-1:0]  flash;
	logic [LEAD_W-1:0]     eff_lead;
	logic [LEAD_W-1:0]     nxt_lead;
	wire logic             any_auto_run_w;
	wire logic             seq_end_w;

	assign any_auto_run_w = |(run_fb_in & hoa_auto_in);
	assign seq_end_w      = (seq_ff == SEQ_PUMP) & lvl.off & ~any_auto_run_w;

	// demand: off level drops all, lag adds the second pump
	assign nxt_need = suspend_w ? NEED_NONE :
	                  lvl.off ? NEED_NONE :
	                  lvl.lag ? NEED_LAG :
	                  (lvl.lead && need_ff == NEED_NONE) ? NEED_LEAD : need_ff;

	// sequence state, ends only at off level with no pump in auto running
	always_comb begin
		nxt_seq = seq_ff;
		case (seq_ff)
			SEQ_IDLE: begin
				if (nxt_need != NEED_NONE) begin
					nxt_seq = SEQ_PUMP;
				end
			end
			SEQ_PUMP: begin
				if (seq_end_w) begin
					nxt_seq = SEQ_IDLE;
				end
			end
			default: begin
				nxt_seq = SEQ_IDLE;
			end
		endcase
	end

	// walk from the lead, skipping pumps out of rotation
	always_comb begin
		int cnt;
		int j;
		logic found;
		cnt = 0;
		j = 0;
		found = 1'b0;
		call = '0;
		eff_lead = lead_ff;
		for (int i = 0; i < NUM_PUMPS; i++) begin
			j = int'(lead_ff) + i;
			if (j >= NUM_PUMPS) begin
				j = j - NUM_PUMPS;
			end
			if (avail[j] && !found) begin
				eff_lead = LEAD_W'(j);
				found = 1'b1;
			end
			if (avail[j] && cnt < int'(need_ff)) begin
				call[j] = 1'b1;
				cnt = cnt + 1;
			end
		end
	end

	// rotation moves past the pump that led the finished sequence
	assign nxt_lead = (int'(eff_lead) == NUM_PUMPS - 1) ? '0 : eff_lead + LEAD_W'(1);

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			seq_ff  <= SEQ_IDLE;
			need_ff <= NEED_NONE;
			lead_ff <= '0;
		end else begin
			seq_ff  <= nxt_seq;
			need_ff <= nxt_need;
			lead_ff <= seq_end_w ? nxt_lead : lead_ff;
		end
	end

	// ----------------------------------------
	// per-pump supervisors
	// ----------------------------------------
	for (genvar p = 0; p < NUM_PUMPS; p++) begin : g_pump
		pmfs_pump_mon u_mon (
			.clock_in     (clock_in),
			.sys_rst_in   (sys_rst_in),
			.sec_tick_in  (sec_tick_ff),
			.cfg_in       (cfg),
			.seq_end_in   (seq_end_w),
			.auto_in      (hoa_auto_in[p]),
			.ovr_in       (remote_ovr_in[p]),
			.call_in      (call[p]),
			.fb_in        (run_fb_in[p]),
			.run_out      (run_out[p]),
			.start_flt_out(start_flt_out[p]),
			.stop_flt_out (stop_flt_out[p]),
			.avail_out    (avail[p]),
			.flash_out    (flash[p])
		);
	end

	// ----------------------------------------
	// alarms, log and indicators
	// ----------------------------------------
	pmfs_alarm_t act;
	pmfs_alarm_t log_ff;
	logic        view_ff;
	logic [NUM_PUMPS-1:0] pump_led_ff;
	logic        alarm_led_ff;
	logic        light_ff;
	logic        horn_ff;
	wire logic   view_exit_w;
	wire logic   any_act_w;

	assign act         = '{start: |start_flt_out, stop: |stop_flt_out, xdcr: xd_fault_ff};
	assign any_act_w   = |act;
	assign view_exit_w = view_ff & ~alarm_view_in;

	// active alarms keep their entry, so a new one is never lost on exit
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			log_ff  <= '0;
			view_ff <= 1'b0;
		end else begin
			log_ff  <= act | (log_ff & ~(view_exit_w ? ~act : '0));
			view_ff <= alarm_view_in;
		end
	end

	// indicators are registered so they switch cleanly with the flash phase
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pump_led_ff  <= '0;
			alarm_led_ff <= 1'b0;
			light_ff     <= 1'b0;
			horn_ff      <= 1'b0;
		end else begin
			pump_led_ff  <= (flash & {NUM_PUMPS{blink_ff}}) | (~flash & run_fb_in);
			alarm_led_ff <= any_act_w ? blink_ff : |log_ff;
			light_ff     <= suspend_w;
			horn_ff      <= suspend_w & horn_en_in;
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	assign pump_led_out     = pump_led_ff;
	assign alarm_act_out    = act;
	assign alarm_log_out    = log_ff;
	assign alarm_led_out    = alarm_led_ff;
	assign alarm_light_out  = light_ff;
	assign horn_out         = horn_ff;
	assign xd_fault_out     = xd_fault_ff;
	assign auto_suspend_out = suspend_w;
	assign seq_active_out   = (seq_ff == SEQ_PUMP);
	assign lead_out         = eff_lead;

endmodule
`default_nettype wire

//--- design/pmfs_pkg.sv
package pmfs_pkg;

	// ----------------------------------------
	// clock and time base
	// ----------------------------------------
	localparam int CLK_HZ       = 25_000_000;
	localparam int TICK_SEC     = 1;
	localparam int TICK_CYCLES  = CLK_HZ * TICK_SEC;
	localparam int FLASH_MS     = 500;
	localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_MS;

	// ----------------------------------------
	// follow delays, in seconds
	// ----------------------------------------
	localparam int             DLY_W   = 9;
	localparam logic [DLY_W-1:0] DLY_OFF = 9'h000;
	localparam logic [DLY_W-1:0] DLY_DEF = 9'h002;
	localparam logic [DLY_W-1:0] DLY_MIN = 9'h002;
	localparam logic [DLY_W-1:0] DLY_MAX = 9'h1fe;
	localparam logic [DLY_W-1:0] DLY_ONE = 9'h001;

	// ----------------------------------------
	// pump count and demand levels
	// ----------------------------------------
	localparam int         PUMPS_DEF = 2;
	localparam int         PUMPS_MAX = 8;
	localparam logic [1:0] NEED_NONE = 2'h0;
	localparam logic [1:0] NEED_LEAD = 2'h1;
	localparam logic [1:0] NEED_LAG  = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {BK_NONE, BK_FLOAT, BK_TIMER, BK_XDCR2, BK_COMBO} pmfs_backup_t;
	typedef enum logic {SEQ_IDLE, SEQ_PUMP} pmfs_seq_t;

	typedef struct packed {
		logic [DLY_W-1:0] start_dly;
		logic [DLY_W-1:0] stop_dly;
		logic             auto_retry;
	} pmfs_cfg_t;

	typedef struct packed {
		logic off;
		logic lead;
		logic lag;
	} pmfs_lvl_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic xdcr;
	} pmfs_alarm_t;

	typedef struct packed {
		logic en_low;
		logic en_hi_float;
		logic en_bubbler;
	} pmfs_xdcfg_t;

endpackage

//--- design/pmfs_pump_mon.sv
`timescale 1ns/10ps
`default_nettype none
module pmfs_pump_mon (
	// clock and reset
	input  wire logic                clock_in,
	input  wire logic                sys_rst_in,
	// time base and configuration
	input  wire logic                sec_tick_in,
	input  wire pmfs_pkg::pmfs_cfg_t cfg_in,
	input  wire logic                seq_end_in,
	// selector, override, demand, feedback
	input  wire logic                auto_in,
	input  wire logic                ovr_in,
	input  wire logic                call_in,
	input  wire logic                fb_in,
	// starter command and fault state
	output logic                     run_out,
	output logic                     start_flt_out,
	output logic                     stop_flt_out,
	output logic                     avail_out,
	output logic                     flash_out
);
	import pmfs_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [DLY_W-1:0] secs_ff;
	logic [DLY_W-1:0] nxt_secs;
	logic             run_ff;
	logic             start_flt_ff;
	logic             lock_ff;
	logic             stop_flt_ff;

	// ----------------------------------------
	// mismatch timing and fault decode
	// ----------------------------------------
	wire logic             cmd_w;
	wire logic             mismatch_w;
	wire logic [DLY_W-1:0] dly_w;
	wire logic             expire_w;
	wire logic             start_set_w;
	wire logic             stop_set_w;
	wire logic             start_clr_w;
	wire logic             stop_clr_w;

	// a locked pump is never driven, a zero delay never locks it
	assign cmd_w       = auto_in & call_in & ~lock_ff;
	assign mismatch_w  = run_ff ^ fb_in;
	assign dly_w       = run_ff ? cfg_in.start_dly : cfg_in.stop_dly;
	assign expire_w    = auto_in & mismatch_w & (dly_w != DLY_OFF)
	                     & (secs_ff >= dly_w);
	assign start_set_w = expire_w & run_ff;
	assign stop_set_w  = expire_w & ~run_ff;
	assign start_clr_w = fb_in | ~auto_in;
	assign stop_clr_w  = cfg_in.auto_retry ? (run_ff & fb_in)
	                     : (~auto_in | ovr_in);

	// seconds only count while out of agreement; tick phase gives up to one second less
	assign nxt_secs = !mismatch_w ? DLY_OFF :
	                  (sec_tick_in && secs_ff != DLY_MAX) ? secs_ff + DLY_ONE : secs_ff;

	// counter and command register
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			secs_ff <= DLY_OFF;
			run_ff  <= 1'b0;
		end else begin
			secs_ff <= nxt_secs;
			run_ff  <= cmd_w;
		end
	end

	// fault latches, a new fault wins over a clear in the same cycle
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			start_flt_ff <= 1'b0;
			lock_ff      <= 1'b0;
			stop_flt_ff  <= 1'b0;
		end else begin
			start_flt_ff <= start_set_w | (start_flt_ff & ~start_clr_w);
			lock_ff      <= start_set_w | (lock_ff & ~seq_end_in);
			stop_flt_ff  <= stop_set_w | (stop_flt_ff & ~stop_clr_w);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign run_out       = run_ff;
	assign start_flt_out = start_flt_ff;
	assign stop_flt_out  = stop_flt_ff;
	// without retry a stop-faulted pump leaves the rotation
	assign avail_out     = auto_in & ~ovr_in & ~lock_ff
	                       & ~(stop_flt_ff & ~cfg_in.auto_retry);
	assign flash_out     = auto_in & (start_flt_ff | stop_flt_ff);

endmodule
`default_nettype wire

//--- test/pmfs_starter_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmfs_starter_model #(
	parameter int NUM_PUMPS = 2
) (
	// clock
	input  wire logic                   clock_in,
	// starter coils and contact behaviour, two bits a pump
	input  wire logic [NUM_PUMPS-1:0]   coil_in,
	input  wire logic [2*NUM_PUMPS-1:0] mode_in,
	// auxiliary run contacts
	output logic      [NUM_PUMPS-1:0]   aux_out
);
	// ----------------
	// contactor lag
	// ----------------
	// a healthy contactor pulls in three cycles after its coil, so the block never sees instant feedback
	logic [NUM_PUMPS-1:0] d1_ff;
	logic [NUM_PUMPS-1:0] d2_ff;
	logic [NUM_PUMPS-1:0] d3_ff;
	always_ff @(posedge clock_in) begin
		d1_ff <= coil_in;
		d2_ff <= d1_ff;
		d3_ff <= d2_ff;
	end
	// mode 1 welded open, mode 2 welded shut, else healthy
	always_comb begin
		for (int i = 0; i < NUM_PUMPS; i++) begin
			case (mode_in[2*i +: 2])
				2'h1: aux_out[i] = 1'b0;
				2'h2: aux_out[i] = 1'b1;
				default: aux_out[i] = d3_ff[i];
			endcase
		end
	end
endmodule
`default_nettype wire

//--- test/pmfs_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pmfs_top_asserts #(
	parameter int NUM_PUMPS   = 2,
	parameter int TICK_CYCLES = 10
) (
	// clock and reset
	input  wire logic                   clock_in,
	input  wire logic                   sys_rst_in,
	// watched inputs
	input  wire logic [NUM_PUMPS-1:0]   hoa_auto_in,
	input  wire logic [NUM_PUMPS-1:0]   run_fb_in,
	input  wire logic [8:0]             start_dly_in,
	input  wire logic                   dly_dflt_in,
	input  wire pmfs_pkg::pmfs_backup_t backup_in,
	input  wire logic                   horn_en_in,
	input  wire logic                   alarm_view_in,
	// watched outputs
	input  wire logic [NUM_PUMPS-1:0]   run_out,
	input  wire logic [NUM_PUMPS-1:0]   start_flt_out,
	input  wire logic [NUM_PUMPS-1:0]   stop_flt_out,
	input  wire pmfs_pkg::pmfs_alarm_t  alarm_act_out,
	input  wire pmfs_pkg::pmfs_alarm_t  alarm_log_out,
	input  wire logic                   alarm_led_out,
	input  wire logic                   horn_out,
	input  wire logic                   xd_fault_out,
	input  wire logic                   auto_suspend_out
);
	import pmfs_pkg::*;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	// ----------------
	// helper logic
	// ----------------
	// cycles pump 0 has been commanded without feedback; the tick base is free running, so allow slack
	logic [31:0] mm_cnt_ff;
	logic [31:0] nxt_mm_cnt;
	logic        any_alarm;
	assign nxt_mm_cnt = (run_out[0] && !run_fb_in[0] && hoa_auto_in[0]) ? mm_cnt_ff + 32'h1 : 32'h0;
	assign any_alarm  = (alarm_act_out != 3'h0) || (alarm_log_out != 3'h0);
	always_ff @(posedge clock_in) begin
		mm_cnt_ff <= sys_rst_in ? 32'h0 : nxt_mm_cnt;
	end
	// ----------------
	// properties
	// ----------------
	run_needs_auto_a:
		assert property (run_out[0] |-> $past(hoa_auto_in[0])) else $error("run without auto");
	start_dly_min_a:
		assert property ($rose(start_flt_out[0]) |-> mm_cnt_ff >= TICK_CYCLES - 2) else $error("fault too early");
	zero_dly_quiet_a:
		assert property ($rose(start_flt_out[0]) |-> $past(start_dly_in) != 9'h000 || $past(dly_dflt_in))
		else $error("fault with zero delay");
	drop_on_fault_a:
		assert property ($rose(start_flt_out[0]) |=> !run_out[0]) else $error("faulted pump still run");
	start_clear_a:
		assert property ($fell(start_flt_out[0]) |-> $past(run_fb_in[0]) || !$past(hoa_auto_in[0]))
		else $error("start fault cleared early");
	start_alarm_a:
		assert property (start_flt_out != '0 |-> alarm_act_out.start) else $error("start alarm missing");
	stop_alarm_a:
		assert property (stop_flt_out != '0 |-> alarm_act_out.stop) else $error("stop alarm missing");
	suspend_map_a:
		assert property (xd_fault_out && backup_in == BK_NONE |-> auto_suspend_out) else $error("no suspend");
	horn_gate_a:
		assert property (horn_out |-> $past(horn_en_in)) else $error("horn while disabled");
	view_exit_log_a:
		assert property (($fell(alarm_view_in) && alarm_act_out == 3'h0) ##1 (alarm_act_out == 3'h0)[*2]
			|-> alarm_log_out == 3'h0) else $error("log kept after exit");
	view_exit_led_a:
		assert property (($fell(alarm_view_in) && alarm_act_out == 3'h0) ##1 (alarm_act_out == 3'h0)[*3]
			|-> !alarm_led_out) else $error("led kept after exit");
	led_cause_a:
		assert property (alarm_led_out |-> any_alarm || $past(any_alarm) || $past(any_alarm, 2))
		else $error("led without alarm");
endmodule
bind pmfs_top pmfs_top_asserts #(.NUM_PUMPS(NUM_PUMPS), .TICK_CYCLES(TICK_CYCLES)) u_pmfs_top_asserts (
	.clock_in, .sys_rst_in, .hoa_auto_in, .run_fb_in, .start_dly_in, .dly_dflt_in, .backup_in, .horn_en_in,
	.alarm_view_in, .run_out, .start_flt_out, .stop_flt_out, .alarm_act_out, .alarm_log_out, .alarm_led_out,
	.horn_out, .xd_fault_out, .auto_suspend_out);
`default_nettype wire

//--- test/pmfs_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH t=%0t line %0d", $time, `__LINE__); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) wt(1);
module pmfs_top_tb;
	import pmfs_pkg::*;
	// ----------------
	// bench signals
	// ----------------
	localparam int NP = 2;
	localparam int TK = 10; // one second shortened to ten cycles
	logic            clock_in = 1'b0;
	logic            sys_rst_in = 1'b1;
	logic [NP-1:0]   hoa_auto_in = 2'h3;
	logic [NP-1:0]   remote_ovr_in = 2'h0;
	logic [NP-1:0]   run_fb_in;
	logic [8:0]      start_dly_in = 9'h003;
	logic [8:0]      stop_dly_in = 9'h003;
	logic            dly_dflt_in = 1'b0;
	logic            auto_retry_in = 1'b0;
	pmfs_xdcfg_t     xd_cfg_in = 3'h0;
	pmfs_backup_t    backup_in = BK_NONE;
	logic            horn_en_in = 1'b0;
	pmfs_lvl_t       lvl_xd1_in = 3'h4;
	pmfs_lvl_t       lvl_xd2_in = 3'h4;
	pmfs_lvl_t       lvl_flt_in = 3'h4;
	logic            timer_call_in = 1'b0;
	logic            xd_low_in = 1'b0;
	logic            bubbler_noise_in = 1'b1;
	logic            xd_reset_in = 1'b0;
	logic            alarm_view_in = 1'b0;
	logic [2*NP-1:0] fb_mode = 4'h0;
	logic [NP-1:0]   run_out;
	logic [NP-1:0]   pump_led_out;
	logic [NP-1:0]   start_flt_out;
	logic [NP-1:0]   stop_flt_out;
	pmfs_alarm_t     alarm_act_out;
	pmfs_alarm_t     alarm_log_out;
	logic            alarm_led_out;
	logic            alarm_light_out;
	logic            horn_out;
	logic            xd_fault_out;
	logic            auto_suspend_out;
	logic            seq_active_out;
	logic [0:0]      lead_out;
	int              num_errors = 0;
	int              num_checks = 0;
	int              cyc = 0;
	// ----------------
	// block and starters
	// ----------------
	pmfs_top #(.NUM_PUMPS(NP), .TICK_CYCLES(TK), .FLASH_CYCLES(4)) u_pmfs_top (
		.clock_in, .sys_rst_in, .hoa_auto_in, .remote_ovr_in, .run_fb_in, .start_dly_in, .stop_dly_in,
		.dly_dflt_in, .auto_retry_in, .xd_cfg_in, .backup_in, .horn_en_in, .lvl_xd1_in, .lvl_xd2_in,
		.lvl_flt_in, .timer_call_in, .hi_float_in(1'b0), .lo_float_in(1'b0), .xd_low_in,
		.bubbler_noise_in, .xd_reset_in, .alarm_view_in, .run_out, .pump_led_out, .start_flt_out,
		.stop_flt_out, .alarm_act_out, .alarm_log_out, .alarm_led_out, .alarm_light_out, .horn_out,
		.xd_fault_out, .auto_suspend_out, .seq_active_out, .lead_out);
	pmfs_starter_model #(.NUM_PUMPS(NP)) u_pmfs_starter_model (
		.clock_in, .coil_in(run_out), .mode_in(fb_mode), .aux_out(run_fb_in));
	// clock and hang guard; the whole run needs well under 2000 cycles
	initial begin
		forever #20 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	// ----------------
	// tasks
	// ----------------
	task automatic wt(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// pump 0 never pulls in: fault, lock-out, retry next cycle
	task automatic t_start();
		int   n;
		logic on1;
		logic on0;
		@(posedge clock_in);
		fb_mode <= 4'h1;
		lvl_xd1_in <= 3'h2;
		`WAITC(run_out[0], 6)
		`CHK(run_out, 2'h1)
		for (n = 0; n < 60 && start_flt_out[0] !== 1'b1; n++) wt(1);
		`CHK(n >= 2*TK-2 && n <= 3*TK+4, 1'b1)
		wt(2);
		`CHK(run_out[0], 1'b0)
		`CHK(alarm_act_out.start, 1'b1)
		on1 = 1'b0;
		on0 = 1'b0;
		repeat (12) begin
			wt(1);
			on1 |= pump_led_out[0];
			on0 |= !pump_led_out[0];
		end
		`CHK(on1 & on0, 1'b1)
		@(posedge clock_in);
		lvl_xd1_in <= 3'h3;
		wt(8);
		`CHK(run_out, 2'h2)
		@(posedge clock_in);
		lvl_xd1_in <= 3'h4;
		wt(12);
		`CHK(seq_active_out, 1'b0)
		`CHK(start_flt_out[0], 1'b1)
		@(posedge clock_in);
		fb_mode <= 4'h0;
		lvl_xd1_in <= 3'h3;
		`WAITC(!start_flt_out[0], 30)
		`CHK(run_out, 2'h3)
		`CHK(start_flt_out[0], 1'b0)
		@(posedge clock_in);
		lvl_xd1_in <= 3'h4;
		wt(12);
	endtask
	// zero delays: no fault, both starters stay commanded
	task automatic t_zero();
		@(posedge clock_in);
		start_dly_in <= 9'h000;
		stop_dly_in <= 9'h000;
		fb_mode <= 4'h1;
		lvl_xd1_in <= 3'h3;
		wt(60);
		`CHK(run_out, 2'h3)
		`CHK(start_flt_out, 2'h0)
		@(posedge clock_in);
		lvl_xd1_in <= 3'h4;
		fb_mode <= 4'h0;
		wt(12);
		@(posedge clock_in);
		start_dly_in <= 9'h003;
		stop_dly_in <= 9'h003;
	endtask
	// pump 0 runs uncalled: held until override, then cleared by retry
	task automatic t_stop();
		@(posedge clock_in);
		stop_dly_in <= 9'h000;
		dly_dflt_in <= 1'b1;
		fb_mode <= 4'h2;
		`WAITC(stop_flt_out[0], 2*TK+4)
		`CHK(stop_flt_out[0], 1'b1)
		`CHK(alarm_act_out.stop, 1'b1)
		@(posedge clock_in);
		fb_mode <= 4'h0;
		dly_dflt_in <= 1'b0;
		stop_dly_in <= 9'h003;
		lvl_xd1_in <= 3'h2;
		wt(40);
		`CHK(stop_flt_out[0], 1'b1)
		`CHK(lead_out, 1'b1)
		`CHK(run_out, 2'h2)
		@(posedge clock_in);
		lvl_xd1_in <= 3'h4;
		remote_ovr_in <= 2'h1;
		wt(12);
		`CHK(stop_flt_out[0], 1'b0)
		`CHK(alarm_log_out, 3'h6)
		repeat (6) begin
			wt(1);
			`CHK(alarm_led_out, 1'b1)
		end
		@(posedge clock_in);
		remote_ovr_in <= 2'h0;
		auto_retry_in <= 1'b1;
		fb_mode <= 4'h2;
		`WAITC(stop_flt_out[0], 3*TK+4)
		`CHK(stop_flt_out[0], 1'b1)
		@(posedge clock_in);
		fb_mode <= 4'h0;
		lvl_xd1_in <= 3'h2;
		`WAITC(!stop_flt_out[0], 20)
		`CHK({stop_flt_out[0], run_out[0]}, 2'h1)
		@(posedge clock_in);
		lvl_xd1_in <= 3'h4;
		alarm_view_in <= 1'b1;
		wt(12);
		@(posedge clock_in);
		alarm_view_in <= 1'b0;
		wt(4);
		`CHK(alarm_log_out, 3'h0)
		`CHK(alarm_led_out, 1'b0)
	endtask
	// transducer low: suspend without backup, then every backup scheme
	task automatic t_xdcr();
		@(posedge clock_in);
		xd_cfg_in <= 3'h4;
		horn_en_in <= 1'b1;
		xd_low_in <= 1'b1;
		wt(4);
		`CHK(xd_fault_out, 1'b1)
		`CHK(alarm_act_out.xdcr, 1'b1)
		`CHK(auto_suspend_out, 1'b1)
		`CHK(alarm_light_out, 1'b1)
		`CHK(horn_out, 1'b1)
		@(posedge clock_in);
		xd_low_in <= 1'b0;
		lvl_flt_in <= 3'h2;
		lvl_xd2_in <= 3'h2;
		timer_call_in <= 1'b1;
		for (logic [2:0] m = 3'h1; m < 3'h5; m++) begin
			@(posedge clock_in);
			backup_in <= pmfs_backup_t'(m);
			wt(8);
			`CHK(run_out != 2'h0 && !auto_suspend_out && xd_fault_out, 1'b1)
		end
		@(posedge clock_in);
		lvl_flt_in <= 3'h4;
		lvl_xd2_in <= 3'h4;
		timer_call_in <= 1'b0;
		xd_reset_in <= 1'b1;
		@(posedge clock_in);
		xd_reset_in <= 1'b0;
		wt(3);
		`CHK(xd_fault_out, 1'b0)
		@(posedge clock_in);
		xd_cfg_in <= 3'h1;
		bubbler_noise_in <= 1'b0;
		wt(3);
		`CHK(xd_fault_out, 1'b1)
	endtask
	// ----------------
	// main sequence
	// ----------------
	initial begin
		repeat (20) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		wt(1);
		`CHK({run_out, start_flt_out, stop_flt_out, alarm_led_out, lead_out}, 8'h00)
		t_start();
		t_zero();
		t_stop();
		t_xdcr();
		report_and_stop();
	end
endmodule
`default_nettype wire
